// >>> ucil_pkg.sv
// Package of offsets, field positions, codes and reset values for the channel interrupt logic
package ucil_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [5:0] OFS_IER = 6'h00;
	localparam logic [5:0] OFS_ISR = 6'h04;
	localparam logic [5:0] OFS_LSR = 6'h08;
	localparam logic [5:0] OFS_MSR = 6'h0C;
	localparam logic [5:0] OFS_RHR = 6'h10;
	localparam logic [5:0] OFS_THR = 6'h14;
	localparam logic [5:0] OFS_CTRL = 6'h18;
	localparam logic [5:0] OFS_SUM = 6'h1C;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] IER_RESET = 8'h00;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [3:0] DELTA_RESET = 4'h0;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int CTRL_FIFO_EN = 0;
	localparam int CTRL_ENH_EN = 1;
	localparam int CTRL_AUTO_RTS = 2;
	localparam int CTRL_AUTO_CTS = 3;
	localparam int CTRL_RS485 = 4;
	localparam int CTRL_PIN_SEL = 5;

	// ****************************************
	// Enable register fields
	// ****************************************
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LINE = 2;
	localparam int IER_MODEM = 3;
	localparam int IER_XCHAR = 5;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;
	localparam logic [7:0] IER_ENH_MASK = 8'hE0;
	localparam logic [7:0] IER_WR_MASK = 8'hEF;

	// ****************************************
	// Status codes, highest priority first
	// ****************************************
	localparam logic [5:0] CODE_LINE = 6'h06;
	localparam logic [5:0] CODE_RXDATA = 6'h04;
	localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
	localparam logic [5:0] CODE_TRANSMIT_READY_INTERRUPT = 6'h02;
	localparam logic [5:0] CODE_MODEM = 6'h00;
	localparam logic [5:0] CODE_XCHAR = 6'h10;
	localparam logic [5:0] CODE_FLOW = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;

	// ****************************************
	// Receive timeout and bus answers
	// ****************************************
	localparam int TIMEOUT_CHARS = 4;
	localparam int TIMEOUT_EXTRA_BITS = 12;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> ucil_rx_timeout.sv
// Receive timeout timer counting bit ticks while characters wait in the receive FIFO
`timescale 1ns/1ps
`default_nettype none
module ucil_rx_timeout (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic armed,
	input wire logic restart,
	input wire logic bit_tick,
	input wire logic [3:0] char_bits,
	output logic expired
);
	import ucil_pkg::*;

	logic [7:0] count_reg, count_next;
	logic expired_reg, expired_next;
	logic [7:0] limit;

	// Four character times plus twelve bit times
	assign limit = 8'(TIMEOUT_CHARS) * {4'h0, char_bits} + 8'(TIMEOUT_EXTRA_BITS);
	assign expired = expired_reg;

	always_comb begin
		count_next = count_reg;
		expired_next = 1'b0;
		// Any traffic restarts the wait so the timeout only flags a stalled receiver
		if (!armed || restart) begin
			count_next = 8'h00;
		end else if (bit_tick && count_reg != limit) begin
			count_next = count_reg + 8'h01;
			expired_next = (count_reg + 8'h01) == limit;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= 8'h00;
			expired_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			expired_reg <= expired_next;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_timeout_once;
		expired |=> !expired;
	endproperty
	a_timeout_once: assert property (p_timeout_once) else $error("timeout pulse longer than one cycle");

endmodule
`default_nettype wire

// >>> ucil_channel_irq.sv
// Channel interrupt logic: enable, prioritised status, line and modem status, AXI4-Lite slave
// Contract
// - FIFO mode: receive interrupt and code follow level at or above trigger.
// - Data-ready bit set when FIFO holds a character, cleared when empty.
// - Bit1 overrun, bits 2..4 head byte errors, bit7 any FIFO error.
// - Bit5 transmit FIFO empty, bit6 FIFO and shift register both empty.
// - Enable bit7, enhanced-only, interrupts on CTS rising transition.
// - Enable bit6, enhanced-only, interrupts on RTS rising transition.
// - Enable bit5, enhanced-only, enables Xoff interrupt; bit4 reserved.
// - Enable bit3 raises modem interrupt when any delta bit sets.
// - Line interrupt on errored arrival, again when it reaches the head.
// - Per-character error bits show only the head byte.
// - Transmit ready: non-FIFO when empty; FIFO on below trigger and on empty.
// - Half-duplex mode delays second transmit interrupt until shift register empty.
// - Receive interrupt: non-FIFO when holding a character; FIFO at trigger.
// - Status read returns only the highest pending source.
// - Receive timeout after four characters plus twelve bits, cleared reading data.
// - Xon, Xoff, special character interrupts; status read clears, special also next char.
// - Wake indicator set leaving sleep, cleared only by summary read.
// - Each source cleared by its own read or write.
// - Codes 06 line, 04 receive data, 0C timeout.
// - Codes 02 transmit, 00 modem, 10 character, 20 flow pin, 01 none.
// - Flow pin interrupts only under matching auto flow; pin pair selectable.
// - Status bit0 low while pending, high when idle and after reset.
// - Status bits 7..6 show FIFO enable.
`timescale 1ns/1ps
`default_nettype none
module ucil_channel_irq #(
	parameter int LVL_W = 7
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [LVL_W-1:0] rx_level,
	input wire logic [LVL_W-1:0] rx_trigger,
	input wire logic [7:0] rx_head_data,
	input wire logic [2:0] rx_head_err,
	input wire logic rx_fifo_err_any,
	input wire logic rx_char_pushed,
	input wire logic rx_push_error,
	input wire logic rx_overrun,
	input wire logic [LVL_W-1:0] tx_level,
	input wire logic [LVL_W-1:0] tx_trigger,
	input wire logic tx_shift_empty,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic cd_n,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic xoff_det,
	input wire logic xon_det,
	input wire logic special_det,
	input wire logic wake_event,
	input wire logic bit_tick,
	input wire logic [3:0] char_bits,
	output logic irq,
	output logic rx_pop,
	output logic tx_write,
	output logic [7:0] tx_data,
	output logic fifo_enable
);
	import ucil_pkg::*;

	// ****************************************
	// Bus slave state
	// ****************************************
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [5:0] waddr_reg, waddr_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic wlane_reg, wlane_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic do_write, do_read;

	// ****************************************
	// Channel state
	// ****************************************
	logic [7:0] ier_reg, ier_next;
	logic [5:0] ctrl_reg, ctrl_next;
	logic lsr_flag_reg, lsr_flag_next, ovr_reg, ovr_next;
	logic to_flag_reg, to_flag_next, tx_flag_reg, tx_flag_next;
	logic xo_flag_reg, xo_flag_next, sp_flag_reg, sp_flag_next;
	logic flow_flag_reg, flow_flag_next, wake_reg, wake_next;
	logic [3:0] delta_reg, delta_next;
	logic [5:0] pins_q_reg;
	logic tx_below_q_reg, tx_empty_q_reg, pop_d_reg;
	logic irq_reg, irq_next, rx_pop_reg, rx_pop_next, tx_write_reg, tx_write_next;
	logic [7:0] tx_data_reg, tx_data_next;
	logic to_expired;

	logic fifo_en, rx_data_pend, any_pend, tx_empty, tx_below, tx_empty_evt;
	logic rd_isr, rd_lsr, rd_msr, rd_rhr, rd_sum, wr_thr, wr_ier;
	logic [5:0] isr_code;
	logic [7:0] isr_value, lsr_value, msr_value;
	logic [5:0] pins_now;

	function automatic logic addr_mapped(input logic [5:0] a);
		return a[5] == 1'b0 && a[1:0] == 2'h0;
	endfunction

	assign fifo_en = ctrl_reg[CTRL_FIFO_EN];
	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign do_read = s_axi_arvalid && arready_reg;
	assign rd_isr = do_read && s_axi_araddr == OFS_ISR;
	assign rd_lsr = do_read && s_axi_araddr == OFS_LSR;
	assign rd_msr = do_read && s_axi_araddr == OFS_MSR;
	assign rd_rhr = do_read && s_axi_araddr == OFS_RHR;
	assign rd_sum = do_read && s_axi_araddr == OFS_SUM;
	assign wr_thr = do_write && wlane_reg && waddr_reg == OFS_THR;
	assign wr_ier = do_write && wlane_reg && waddr_reg == OFS_IER;

	// ****************************************
	// Line and modem status
	// ****************************************
	assign tx_empty = tx_level == '0;
	assign tx_below = tx_level < tx_trigger;
	// In half-duplex mode the line may only turn round once the shift register drains
	assign tx_empty_evt = ctrl_reg[CTRL_RS485] ? (tx_empty && tx_shift_empty) : tx_empty;
	assign lsr_value = {rx_fifo_err_any && fifo_en,
		tx_empty && tx_shift_empty, tx_empty,
		rx_head_err,
		ovr_reg,
		rx_level != '0};
	assign pins_now = {dtr_n, rts_n, cd_n, ri_n, dsr_n, cts_n};
	assign msr_value = {~cd_n, ~ri_n, ~dsr_n, ~cts_n, delta_reg};

	// ****************************************
	// Priority encoder
	// ****************************************
	// Non-FIFO mode has a single holding slot, so any character counts
	assign rx_data_pend = fifo_en ? (rx_level >= rx_trigger && rx_level != '0) : (rx_level != '0);
	always_comb begin
		// Only the top source is shown; the rest wait until it is serviced
		if (lsr_flag_reg && ier_reg[IER_LINE]) begin
			isr_code = CODE_LINE;
		end else if (rx_data_pend && ier_reg[IER_RX]) begin
			isr_code = CODE_RXDATA;
		end else if (to_flag_reg && ier_reg[IER_RX]) begin
			isr_code = CODE_TIMEOUT;
		end else if (tx_flag_reg && ier_reg[IER_TX]) begin
			isr_code = CODE_TRANSMIT_READY_INTERRUPT;
		end else if ((|delta_reg) && ier_reg[IER_MODEM]) begin
			isr_code = CODE_MODEM;
		end else if (xo_flag_reg || sp_flag_reg) begin
			isr_code = CODE_XCHAR;
		end else if (flow_flag_reg && (ier_reg[IER_CTS] || ier_reg[IER_RTS])) begin
			isr_code = CODE_FLOW;
		end else begin
			isr_code = CODE_NONE;
		end
	end
	assign isr_value = {fifo_en, fifo_en, isr_code};
	assign any_pend = isr_code != CODE_NONE || wake_reg;

	// ****************************************
	// Receive timeout timer
	// ****************************************
	ucil_rx_timeout u_timeout (
		.aclk(aclk),
		.aresetn(aresetn),
		.armed(fifo_en && rx_level != '0),
		.restart(rx_char_pushed || rx_pop_reg),
		.bit_tick(bit_tick),
		.char_bits(char_bits),
		.expired(to_expired)
	);

	// ****************************************
	// Interrupt sources
	// ****************************************
	always_comb begin
		logic flow_rise;
		flow_rise = 1'b0;
		ier_next = ier_reg;
		ctrl_next = ctrl_reg;
		if (wr_ier) begin
			// Top three enables are locked unless enhanced functions are on
			if (ctrl_reg[CTRL_ENH_EN]) begin
				ier_next = wbyte_reg & IER_WR_MASK;
			end else begin
				ier_next = (ier_reg & IER_ENH_MASK) | (wbyte_reg & ~IER_ENH_MASK & IER_WR_MASK);
			end
		end
		if (do_write && wlane_reg && waddr_reg == OFS_CTRL) begin
			ctrl_next = wbyte_reg[5:0];
		end
		// Every flag: a set in the same cycle as its clear wins
		lsr_flag_next = rd_lsr ? 1'b0 : lsr_flag_reg;
		lsr_flag_next = lsr_flag_next || (rx_char_pushed && rx_push_error) || rx_overrun
			|| (pop_d_reg && (|rx_head_err));
		ovr_next = (rd_lsr ? 1'b0 : ovr_reg) || rx_overrun;
		to_flag_next = (rd_rhr ? 1'b0 : to_flag_reg) || to_expired;
		tx_flag_next = (((rd_isr && isr_code == CODE_TRANSMIT_READY_INTERRUPT) || wr_thr) ? 1'b0 : tx_flag_reg);
		if (fifo_en) begin
			tx_flag_next = tx_flag_next || (tx_below && !tx_below_q_reg) || (tx_empty_evt && !tx_empty_q_reg);
		end else begin
			tx_flag_next = tx_flag_next || (tx_empty && !tx_empty_q_reg);
		end
		if (wr_ier && wbyte_reg[IER_TX] && !ier_reg[IER_TX] && tx_empty_evt) begin
			tx_flag_next = 1'b1;
		end
		xo_flag_next = ((rd_isr && isr_code == CODE_XCHAR) ? 1'b0 : xo_flag_reg)
			|| (ier_reg[IER_XCHAR] && (xoff_det || xon_det));
		sp_flag_next = (((rd_isr && isr_code == CODE_XCHAR) || rx_char_pushed) ? 1'b0 : sp_flag_reg)
			|| (ier_reg[IER_XCHAR] && special_det);
		delta_next = rd_msr ? DELTA_RESET : delta_reg;
		delta_next[0] = delta_next[0] || (cts_n != pins_q_reg[0]);
		delta_next[1] = delta_next[1] || (dsr_n != pins_q_reg[1]);
		delta_next[2] = delta_next[2] || (ri_n && !pins_q_reg[2]);
		delta_next[3] = delta_next[3] || (cd_n != pins_q_reg[3]);
		// The pin pair watched follows the selected flow pair
		if (ctrl_reg[CTRL_AUTO_CTS] && ier_reg[IER_CTS]) begin
			flow_rise = ctrl_reg[CTRL_PIN_SEL] ? (dsr_n && !pins_q_reg[1]) : (cts_n && !pins_q_reg[0]);
		end
		if (ctrl_reg[CTRL_AUTO_RTS] && ier_reg[IER_RTS]) begin
			flow_rise = flow_rise || (ctrl_reg[CTRL_PIN_SEL] ? (dtr_n && !pins_q_reg[5]) : (rts_n && !pins_q_reg[4]));
		end
		flow_flag_next = (rd_msr ? 1'b0 : flow_flag_reg) || flow_rise;
		wake_next = (rd_sum ? 1'b0 : wake_reg) || wake_event;
		irq_next = any_pend;
		rx_pop_next = rd_rhr;
		tx_write_next = wr_thr;
		tx_data_next = wr_thr ? wbyte_reg : tx_data_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ier_reg <= IER_RESET;
			ctrl_reg <= CTRL_RESET;
			lsr_flag_reg <= 1'b0;
			ovr_reg <= 1'b0;
			to_flag_reg <= 1'b0;
			tx_flag_reg <= 1'b0;
			xo_flag_reg <= 1'b0;
			sp_flag_reg <= 1'b0;
			flow_flag_reg <= 1'b0;
			wake_reg <= 1'b0;
			delta_reg <= DELTA_RESET;
			pins_q_reg <= 6'h3F;
			tx_below_q_reg <= 1'b1;
			tx_empty_q_reg <= 1'b1;
			pop_d_reg <= 1'b0;
			irq_reg <= 1'b0;
			rx_pop_reg <= 1'b0;
			tx_write_reg <= 1'b0;
			tx_data_reg <= 8'h00;
		end else begin
			ier_reg <= ier_next;
			ctrl_reg <= ctrl_next;
			lsr_flag_reg <= lsr_flag_next;
			ovr_reg <= ovr_next;
			to_flag_reg <= to_flag_next;
			tx_flag_reg <= tx_flag_next;
			xo_flag_reg <= xo_flag_next;
			sp_flag_reg <= sp_flag_next;
			flow_flag_reg <= flow_flag_next;
			wake_reg <= wake_next;
			delta_reg <= delta_next;
			pins_q_reg <= pins_now;
			tx_below_q_reg <= tx_below;
			tx_empty_q_reg <= fifo_en ? tx_empty_evt : tx_empty;
			pop_d_reg <= rx_pop_reg;
			irq_reg <= irq_next;
			rx_pop_reg <= rx_pop_next;
			tx_write_reg <= tx_write_next;
			tx_data_reg <= tx_data_next;
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	always_comb begin
		awready_next = s_axi_awvalid && !awready_reg && !aw_held_reg && !bvalid_reg;
		wready_next = s_axi_wvalid && !wready_reg && !w_held_reg && !bvalid_reg;
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		waddr_next = waddr_reg;
		wbyte_next = wbyte_reg;
		wlane_next = wlane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && awready_reg) begin
			aw_held_next = 1'b1;
			waddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_held_next = 1'b1;
			wbyte_next = s_axi_wdata[7:0];
			wlane_next = s_axi_wstrb[0];
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = addr_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		arready_next = s_axi_arvalid && !arready_reg && !rvalid_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (do_read) begin
			rvalid_next = 1'b1;
			rresp_next = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				OFS_IER: rdata_next = {24'h000000, ier_reg};
				OFS_ISR: rdata_next = {24'h000000, isr_value};
				OFS_LSR: rdata_next = {24'h000000, lsr_value};
				OFS_MSR: rdata_next = {24'h000000, msr_value};
				OFS_RHR: rdata_next = {24'h000000, rx_head_data};
				OFS_CTRL: rdata_next = {26'h0000000, ctrl_reg};
				OFS_SUM: rdata_next = {30'h00000000, wake_reg, irq_reg};
				default: rdata_next = 32'h00000000;
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			waddr_reg <= 6'h00;
			wbyte_reg <= 8'h00;
			wlane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else begin
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			waddr_reg <= waddr_next;
			wbyte_reg <= wbyte_next;
			wlane_reg <= wlane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign irq = irq_reg;
	assign rx_pop = rx_pop_reg;
	assign tx_write = tx_write_reg;
	assign tx_data = tx_data_reg;
	assign fifo_enable = ctrl_reg[CTRL_FIFO_EN];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_irq_set;
		any_pend |=> irq;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq missed a pending source");

	property p_irq_clr;
		!any_pend |=> !irq;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("irq stayed high with nothing pending");

	property p_line_top;
		lsr_flag_reg && ier_reg[IER_LINE] |-> isr_value[5:0] == 6'h06;
	endproperty
	a_line_top: assert property (p_line_top) else $error("line status not at top priority");

	property p_rx_code;
		fifo_en && ier_reg[IER_RX] && rx_level >= rx_trigger && rx_level != '0 && !lsr_flag_reg
			|-> isr_value[5:0] == 6'h04;
	endproperty
	a_rx_code: assert property (p_rx_code) else $error("receive data code wrong");

	property p_idle_bit;
		(isr_value[0] == 1'b1) == (isr_value[5:1] == 5'h00 && !(|delta_reg && ier_reg[IER_MODEM]));
	endproperty
	a_idle_bit: assert property (p_idle_bit) else $error("status bit0 disagrees with pending");

	property p_fifo_bits;
		isr_value[7:6] == {2{fifo_en}};
	endproperty
	a_fifo_bits: assert property (p_fifo_bits) else $error("status bits 7..6 wrong");

	property p_delta_cts;
		$changed(cts_n) |=> delta_reg[0];
	endproperty
	a_delta_cts: assert property (p_delta_cts) else $error("delta bit for CTS not set");

	property p_ier_lock;
		wr_ier && !ctrl_reg[CTRL_ENH_EN] |=> ier_reg[7:5] == $past(ier_reg[7:5]);
	endproperty
	a_ier_lock: assert property (p_ier_lock) else $error("locked enable bits changed");

	property p_thr_clears;
		wr_thr && !(tx_below && !tx_below_q_reg) && !(tx_empty_evt && !tx_empty_q_reg)
			&& !(tx_empty && !tx_empty_q_reg) |=> !tx_flag_reg && tx_write && tx_data == $past(wbyte_reg);
	endproperty
	a_thr_clears: assert property (p_thr_clears) else $error("holding write did not clear tx ready");

	property p_rd_answer;
		do_read |=> s_axi_rvalid && (!$past(rd_isr) || s_axi_rdata[7:0] == $past(isr_value));
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer not one cycle after address");

	c_line: cover property (rx_char_pushed && rx_push_error ##[1:20] rd_lsr);
	c_tx: cover property (fifo_en && tx_flag_reg ##[1:50] wr_thr);
	c_timeout: cover property (to_expired ##[1:20] rd_rhr);
	c_flow: cover property (flow_flag_reg ##[1:20] rd_msr);

endmodule
`default_nettype wire

// >>> ucil_chan_model.sv
// Behavioural receive FIFO of the channel, answering pops from the interrupt logic
`timescale 1ns/1ps
`default_nettype none
module ucil_chan_model #(
	parameter int LVL_W = 7
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic push,
	input wire logic rx_pop,
	output logic [LVL_W-1:0] rx_level,
	output logic rx_char_pushed,
	output logic [7:0] rx_head_data
);
	logic [7:0] pops_reg;
	// Head byte names its position so every pop shows a fresh value
	assign rx_head_data = 8'h50 + pops_reg;
	assign rx_char_pushed = push;
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_level <= '0;
			pops_reg <= 8'h00;
		end else begin
			rx_level <= rx_level + LVL_W'(push) - LVL_W'(rx_pop && rx_level != 0);
			pops_reg <= pops_reg + 8'(rx_pop);
		end
	end
endmodule
`default_nettype wire

// >>> tb.sv
// Testbench of the channel interrupt logic over its register bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
	import ucil_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, push, rx_pop, rx_char_pushed, irq, tx_write;
	logic rx_fifo_err_any, rx_push_error, rx_overrun, tx_shift_empty, fifo_enable, bit_tick;
	logic cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, xoff_det, xon_det, special_det, wake_event;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, char_bits;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [6:0] rx_level, rx_trigger, tx_level, tx_trigger;
	logic [7:0] rx_head_data, tx_data;
	logic [2:0] rx_head_err;
	int fails = 0;
	int tests_run = 0;
	int tx_writes = 0;
	ucil_channel_irq #(.LVL_W(7)) ucil_channel_irq_i (.*);
	ucil_chan_model #(.LVL_W(7)) ucil_chan_model_i (.*);
	always #10 aclk = ~aclk;
	always @(negedge aclk) if (tx_write === 1'b1) tx_writes++;
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Ready and answer are looked at mid-cycle, the value the next rising edge samples
	task automatic axi_wr(input logic [5:0] a, input logic [7:0] v);
		logic ar, wr, br;
		logic [1:0] bs;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(negedge aclk);
			ar = s_axi_awready;
			wr = s_axi_wready;
			br = s_axi_bvalid;
			bs = s_axi_bresp;
			@(posedge aclk);
			if (ar) s_axi_awvalid <= 1'b0;
			if (wr) s_axi_wvalid <= 1'b0;
			if (br) begin
				`CHK("bresp", RESP_OKAY, bs)
				return;
			end
		end
	endtask
	task automatic axi_rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ar, rv;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(negedge aclk);
			ar = s_axi_arready;
			rv = s_axi_rvalid;
			v = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (rv) return;
		end
	endtask
	task automatic pulse_push(input logic err);
		push <= 1'b1;
		rx_push_error <= err;
		@(posedge aclk);
		push <= 1'b0;
		rx_push_error <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	initial begin
		repeat (5000) @(posedge aclk);
		fails++;
		final_report();
	end
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, push} = '0;
		{rx_fifo_err_any, rx_push_error, rx_overrun, bit_tick, xoff_det, xon_det, special_det, wake_event} = '0;
		{cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n, tx_shift_empty} = '1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_head_err, tx_level} = '0;
		s_axi_wstrb = 4'hF;
		char_bits = 4'hA;
		rx_trigger = 7'h02;
		tx_trigger = 7'h01;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_reset", 8'h01, d[7:0])
		axi_rd(6'h20, d, r);
		`CHK("unmapped", RESP_SLVERR, r)
		axi_wr(OFS_CTRL, 8'h01);
		`CHK("fifo_en", 1'b1, fifo_enable)
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_fifo", 8'hC1, d[7:0])
		axi_wr(OFS_IER, 8'hFF);
		axi_rd(OFS_IER, d, r);
		`CHK("ier_plain", 8'h0F, d[7:0])
		axi_wr(OFS_IER, 8'h0D);
		pulse_push(1'b0);
		axi_rd(OFS_LSR, d, r);
		`CHK("lsr_ready", 8'h61, d[7:0])
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_below", 8'hC1, d[7:0])
		pulse_push(1'b0);
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_rx", 8'hC4, d[7:0])
		`CHK("irq_rx", 1'b1, irq)
		pulse_push(1'b1);
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_line", 8'hC6, d[7:0])
		axi_rd(OFS_LSR, d, r);
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_line_clr", 8'hC4, d[7:0])
		cts_n <= 1'b0;
		axi_rd(OFS_RHR, d, r);
		`CHK("rhr0", 8'h50, d[7:0])
		axi_rd(OFS_RHR, d, r);
		`CHK("rhr1", 8'h51, d[7:0])
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_modem", 8'hC0, d[7:0])
		axi_rd(OFS_MSR, d, r);
		`CHK("msr", 8'h11, d[7:0])
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_idle", 8'hC1, d[7:0])
		repeat (2) @(negedge aclk);
		`CHK("irq_idle", 1'b0, irq)
		bit_tick <= 1'b1;
		repeat (60) @(posedge aclk);
		bit_tick <= 1'b0;
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_timeout", 8'hCC, d[7:0])
		axi_rd(OFS_RHR, d, r);
		`CHK("rhr2", 8'h52, d[7:0])
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_to_clr", 8'hC1, d[7:0])
		tx_level <= 7'h02;
		axi_wr(OFS_IER, 8'h0F);
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_tx", 8'hC2, d[7:0])
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_tx_rd", 8'hC1, d[7:0])
		tx_level <= 7'h00;
		repeat (2) @(posedge aclk);
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_tx_empty", 8'hC2, d[7:0])
		tx_level <= 7'h02;
		@(posedge aclk);
		tx_level <= 7'h00;
		axi_wr(OFS_THR, 8'hA5);
		axi_rd(OFS_ISR, d, r);
		`CHK("isr_tx_wr", 8'hC1, d[7:0])
		`CHK("tx_data", 8'hA5, tx_data)
		`CHK("tx_writes", 1, tx_writes)
		axi_wr(OFS_IER, 8'h00);
		rx_overrun <= 1'b1;
		@(posedge aclk);
		rx_overrun <= 1'b0;
		axi_rd(OFS_LSR, d, r);
		`CHK("lsr_overrun", 8'h62, d[7:0])
		axi_rd(OFS_LSR, d, r);
		`CHK("lsr_poll", 8'h60, d[7:0])
		wake_event <= 1'b1;
		@(posedge aclk);
		wake_event <= 1'b0;
		axi_rd(OFS_SUM, d, r);
		`CHK("sum_wake", 8'h03, d[7:0])
		axi_rd(OFS_SUM, d, r);
		`CHK("sum_clr", 8'h00, d[7:0])
		final_report();
	end
endmodule
`default_nettype wire
